// ===== core/uabd_pkg.sv
package uabd_pkg;
  // ==========================================================
  // register map, byte-wide registers on a plain port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DIV_LOW = 3'h1;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h2;
  localparam logic [2:0] ADDR_RX_BUF = 3'h3;
  localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADDR_STATUS = 3'h6;
  localparam logic [2:0] ADDR_TX_BUF = 3'h7;
  // ==========================================================
  // control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_WAKE_BIT = 1;
  localparam int CTRL_ASYNC_BIT = 2;
  localparam int CTRL_WIDE_BIT = 3;
  localparam int CTRL_HS_BIT = 4;
  localparam int CTRL_OVF_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h04;
  // ==========================================================
  // status, interrupt fields and reset values
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_OVF_BIT = 1;
  localparam int STAT_RXF_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [15:0] DIV_ALL_ONES = 16'hffff;
  // ==========================================================
  // counter clock dividers for settings 00, 01, 10, 11 and calibration slowdown
  localparam logic [11:0] PRESC_DIV_00 = 12'd512;
  localparam logic [11:0] PRESC_DIV_01 = 12'd128;
  localparam logic [11:0] PRESC_DIV_10 = 12'd128;
  localparam logic [11:0] PRESC_DIV_11 = 12'd32;
  localparam int CAL_SLOWDOWN = 8;
  // rising edges seen after the first one before the byte ends
  localparam logic [1:0] LAST_RISE_COUNT = 2'd3;
  // rate generator clocks per divisor step
  localparam logic [6:0] GEN_Q_WIDE_HS = 7'd4;
  localparam logic [6:0] GEN_Q_MID = 7'd16;
  localparam logic [6:0] GEN_Q_NARROW_LS = 7'd64;
  typedef enum logic [2:0] {
    UABD_IDLE, UABD_CLEAR, UABD_WAIT_BREAK, UABD_WAIT_START, UABD_WAIT_RISE, UABD_COUNT
  } uabd_state_e;
endpackage

// ===== core/uabd_tick_if.sv
interface uabd_tick_if;
  logic wide;
  logic high_speed;
  logic run;
  logic tick;
  modport src (input wide, input high_speed, input run, output tick);
  modport ctl (output wide, output high_speed, output run, input tick);
endinterface

// ===== core/uabd_sync.sv
module uabd_sync (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, active high
  input wire logic pin_in, // raw pin level
  output logic level_out // filtered level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // idle line is high; a change counts only when stages two and three agree
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      level_out <= 1'b1;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule

// ===== core/uabd_presc.sv
module uabd_presc (
  input wire logic clk_sys, // system clock
  input wire logic reset, // async reset, active high
  uabd_tick_if.src tp // counter clock request and tick
);
  logic [11:0] base;
  logic [14:0] limit;
  logic [14:0] cnt_r;

  always_comb begin
    case ({tp.wide, tp.high_speed})
      2'b00: base = uabd_pkg::PRESC_DIV_00;
      2'b01: base = uabd_pkg::PRESC_DIV_01;
      2'b10: base = uabd_pkg::PRESC_DIV_10;
      default: base = uabd_pkg::PRESC_DIV_11;
    endcase
    limit = 15'({3'h0, base} * 15'(uabd_pkg::CAL_SLOWDOWN)) - 15'h1;
  end

  // stopped counter restarts from zero so each measurement has a clean phase
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_r <= 15'h0;
      tp.tick <= 1'b0;
    end else if (!tp.run) begin
      cnt_r <= 15'h0;
      tp.tick <= 1'b0;
    end else if (cnt_r >= limit) begin
      cnt_r <= 15'h0;
      tp.tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 15'h1;
      tp.tick <= 1'b0;
    end
  end

  tick_spacing_a: assert property (@(posedge clk_sys) disable iff (reset) tp.tick |=> !tp.tick [*8])
    else $error("counter clock ticks too close together");
endmodule

// ===== core/uabd_top.sv
// The implementer's own choices: the strobed register port and the placing of the registers.
module uabd_top (
  input wire logic clk_sys, // system clock, 25 MHz
  input wire logic reset, // async reset, active high
  input wire logic [2:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic serial_input_pin, // serial receive pin
  output logic irq, // level interrupt
  output logic rate_tick, // rate generator output tick
  output logic tx_lockout, // transmitter blocked
  output logic tx_load, // transmit buffer accepted, one cycle
  output logic [7:0] tx_data, // accepted transmit byte
  output logic rx_hold_idle // receive machine held idle
);
  // ==========================================================
  // state
  logic [7:0] ctrl_r;
  logic [15:0] div_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic receive_flag_r;
  logic [1:0] rise_cnt_r;
  logic rx_prev_r;
  logic rx_lvl;
  logic rise;
  logic fall;
  logic done;
  logic ovf_evt;
  logic [1:0] irq_stat_nxt;
  logic [22:0] gen_cnt_r;
  logic [22:0] gen_period;
  logic [6:0] gen_q;
  uabd_pkg::uabd_state_e state_r;
  uabd_tick_if tif ();

  wire auto_rate_enable = ctrl_r[uabd_pkg::CTRL_EN_BIT];
  wire wake_on_break_enable = ctrl_r[uabd_pkg::CTRL_WAKE_BIT];
  wire async_sel = ctrl_r[uabd_pkg::CTRL_ASYNC_BIT];
  wire wide_divisor_select = ctrl_r[uabd_pkg::CTRL_WIDE_BIT];
  wire high_speed_select = ctrl_r[uabd_pkg::CTRL_HS_BIT];

  function automatic logic hit(input logic [2:0] a, input logic [2:0] target);
    hit = (a == target);
  endfunction

  // ==========================================================
  // serial input and counter clock
  uabd_sync u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin_in(serial_input_pin),
    .level_out(rx_lvl)
  );

  assign tif.wide = wide_divisor_select;
  assign tif.high_speed = high_speed_select;
  assign tif.run = (state_r == uabd_pkg::UABD_COUNT);

  uabd_presc u_presc (
    .clk_sys(clk_sys),
    .reset(reset),
    .tp(tif.src)
  );

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_prev_r <= 1'b1;
    end else begin
      rx_prev_r <= rx_lvl;
    end
  end
  assign rise = rx_lvl && !rx_prev_r;
  assign fall = !rx_lvl && rx_prev_r;
  assign done = (state_r == uabd_pkg::UABD_COUNT) && rise && (rise_cnt_r == uabd_pkg::LAST_RISE_COUNT);
  assign ovf_evt = (state_r == uabd_pkg::UABD_COUNT) && tif.tick && (div_r == uabd_pkg::DIV_ALL_ONES);

  // ==========================================================
  // measurement sequence
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_r <= uabd_pkg::UABD_IDLE;
      rise_cnt_r <= 2'h0;
    end else if (!auto_rate_enable || !async_sel) begin
      state_r <= uabd_pkg::UABD_IDLE;
      rise_cnt_r <= 2'h0;
    end else begin
      case (state_r)
        uabd_pkg::UABD_IDLE: begin
          state_r <= uabd_pkg::UABD_CLEAR;
        end
        uabd_pkg::UABD_CLEAR: begin
          state_r <= wake_on_break_enable ? uabd_pkg::UABD_WAIT_BREAK : uabd_pkg::UABD_WAIT_START;
        end
        uabd_pkg::UABD_WAIT_BREAK: begin
          // the break ends on its rising edge; the next start bit begins the sync byte
          if (rise) begin
            state_r <= uabd_pkg::UABD_WAIT_START;
          end
        end
        uabd_pkg::UABD_WAIT_START: begin
          if (wake_on_break_enable) begin
            state_r <= uabd_pkg::UABD_WAIT_BREAK;
          end else if (fall) begin
            state_r <= uabd_pkg::UABD_WAIT_RISE;
          end
        end
        uabd_pkg::UABD_WAIT_RISE: begin
          if (rise) begin
            state_r <= uabd_pkg::UABD_COUNT;
            rise_cnt_r <= 2'h0;
          end
        end
        uabd_pkg::UABD_COUNT: begin
          if (done) begin
            state_r <= uabd_pkg::UABD_IDLE;
          end else if (rise) begin
            rise_cnt_r <= rise_cnt_r + 2'h1;
          end
        end
        default: begin
          state_r <= uabd_pkg::UABD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // control register; hardware clears enable and wake, sets overflow
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_r <= uabd_pkg::CTRL_RESET;
    end else begin
      if (reg_wr && hit(reg_addr, uabd_pkg::ADDR_CTRL)) begin
        ctrl_r <= reg_wdata;
      end else begin
        if (done) begin
          ctrl_r[uabd_pkg::CTRL_EN_BIT] <= 1'b0;
        end
        if (state_r == uabd_pkg::UABD_WAIT_BREAK && rise) begin
          ctrl_r[uabd_pkg::CTRL_WAKE_BIT] <= 1'b0;
        end
      end
      if (ovf_evt) begin
        ctrl_r[uabd_pkg::CTRL_OVF_BIT] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // divisor pair: one 16-bit counter while measuring, whatever the width
  // writes land while waiting for the start bit, so a preload can provoke a rollover
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_r <= uabd_pkg::DIV_RESET;
    end else if (state_r == uabd_pkg::UABD_CLEAR) begin
      div_r <= uabd_pkg::DIV_RESET;
    end else if (state_r == uabd_pkg::UABD_COUNT) begin
      if (tif.tick) begin
        div_r <= div_r + 16'h1;
      end
    end else if (reg_wr && hit(reg_addr, uabd_pkg::ADDR_DIV_LOW)) begin
      div_r[7:0] <= reg_wdata;
    end else if (reg_wr && hit(reg_addr, uabd_pkg::ADDR_DIV_HIGH)) begin
      div_r[15:8] <= reg_wdata;
    end
  end

  // ==========================================================
  // rate generator, stopped while the enable reverses its clocking
  always_comb begin
    if (wide_divisor_select) begin
      gen_q = high_speed_select ? uabd_pkg::GEN_Q_WIDE_HS : uabd_pkg::GEN_Q_MID;
      gen_period = 23'({16'h0, gen_q} * ({7'h0, div_r} + 23'h1));
    end else begin
      gen_q = high_speed_select ? uabd_pkg::GEN_Q_MID : uabd_pkg::GEN_Q_NARROW_LS;
      gen_period = 23'({16'h0, gen_q} * ({15'h0, div_r[7:0]} + 23'h1));
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gen_cnt_r <= 23'h0;
      rate_tick <= 1'b0;
    end else if (auto_rate_enable) begin
      gen_cnt_r <= 23'h0;
      rate_tick <= 1'b0;
    end else if (gen_cnt_r >= gen_period - 23'h1) begin
      gen_cnt_r <= 23'h0;
      rate_tick <= 1'b1;
    end else begin
      gen_cnt_r <= gen_cnt_r + 23'h1;
      rate_tick <= 1'b0;
    end
  end

  // ==========================================================
  // receive flag, interrupts, transmit gate, read port
  assign irq_stat_nxt = (reg_rd && hit(reg_addr, uabd_pkg::ADDR_IRQ_STATUS) ? 2'h0 : irq_stat_r)
                        | {ovf_evt, done};

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      receive_flag_r <= 1'b0;
      irq_stat_r <= 2'h0;
      irq_mask_r <= uabd_pkg::IRQ_MASK_RESET;
      irq <= 1'b0;
    end else begin
      // a set in the same cycle as the clearing read wins
      if (done) begin
        receive_flag_r <= 1'b1;
      end else if (reg_rd && hit(reg_addr, uabd_pkg::ADDR_RX_BUF)) begin
        receive_flag_r <= 1'b0;
      end
      irq_stat_r <= irq_stat_nxt;
      if (reg_wr && hit(reg_addr, uabd_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_r <= reg_wdata[1:0];
      end
      irq <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // transmit writes while enabled are dropped; the shifter shares the generator clock
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_load <= 1'b0;
      tx_data <= 8'h00;
      tx_lockout <= 1'b0;
      rx_hold_idle <= 1'b0;
    end else begin
      tx_load <= reg_wr && hit(reg_addr, uabd_pkg::ADDR_TX_BUF) && !auto_rate_enable;
      if (reg_wr && hit(reg_addr, uabd_pkg::ADDR_TX_BUF) && !auto_rate_enable) begin
        tx_data <= reg_wdata;
      end
      tx_lockout <= auto_rate_enable;
      rx_hold_idle <= (state_r != uabd_pkg::UABD_IDLE);
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (!reg_rd) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        uabd_pkg::ADDR_CTRL: reg_rdata <= ctrl_r;
        uabd_pkg::ADDR_DIV_LOW: reg_rdata <= div_r[7:0];
        uabd_pkg::ADDR_DIV_HIGH: reg_rdata <= div_r[15:8];
        uabd_pkg::ADDR_IRQ_STATUS: reg_rdata <= {6'h0, irq_stat_r};
        uabd_pkg::ADDR_IRQ_MASK: reg_rdata <= {6'h0, irq_mask_r};
        uabd_pkg::ADDR_STATUS: reg_rdata <= {6'h0, state_r != uabd_pkg::UABD_IDLE, receive_flag_r};
        default: reg_rdata <= 8'h00; // receive buffer contents are meaningless here
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  mode_gate_a: assert property (!async_sel |=> state_r == uabd_pkg::UABD_IDLE)
    else $error("measurement active outside asynchronous mode");
  start_bit_a: assert property (state_r == uabd_pkg::UABD_WAIT_START && auto_rate_enable && async_sel
                                && !wake_on_break_enable && fall |=> state_r == uabd_pkg::UABD_WAIT_RISE)
    else $error("start bit not taken");
  arm_clear_a: assert property (state_r == uabd_pkg::UABD_CLEAR |=> div_r == 16'h0000)
    else $error("divisor not cleared on arm");
  count_step_a: assert property (state_r == uabd_pkg::UABD_COUNT && tif.tick && !done
                                 |=> div_r == $past(div_r) + 16'h1)
    else $error("counter did not step on tick");
  fifth_edge_a: assert property (done |=> !auto_rate_enable && receive_flag_r ##1 irq_stat_r[0])
    else $error("fifth edge did not finish");
  overflow_trap_a: assert property (ovf_evt && !done |=> ctrl_r[uabd_pkg::CTRL_OVF_BIT] && div_r == 16'h0000
                                    && auto_rate_enable)
    else $error("rollover not trapped");
  gen_quiet_a: assert property (auto_rate_enable |=> !rate_tick && gen_cnt_r == 23'h0)
    else $error("rate generator ran while measuring");
  tx_refuse_a: assert property (auto_rate_enable && reg_wr && reg_addr == uabd_pkg::ADDR_TX_BUF |=> !tx_load)
    else $error("transmit write accepted while locked");
  rx_idle_a: assert property (state_r == uabd_pkg::UABD_COUNT |=> rx_hold_idle)
    else $error("receiver not held idle");
  irq_level_a: assert property (|(irq_stat_r & irq_mask_r) && !(reg_rd && reg_addr == uabd_pkg::ADDR_IRQ_STATUS)
                                |=> irq)
    else $error("interrupt missing");

  // ==========================================================
  // side effects, lock-outs and the read port
  wake_clear_a: assert property (state_r == uabd_pkg::UABD_WAIT_BREAK && rise && auto_rate_enable && async_sel
                                 && !(reg_wr && reg_addr == uabd_pkg::ADDR_CTRL)
                                 |=> !wake_on_break_enable && state_r == uabd_pkg::UABD_WAIT_START)
    else $error("break end not taken");
  abort_idle_a: assert property (!auto_rate_enable |=> state_r == uabd_pkg::UABD_IDLE)
    else $error("sequence kept running with enable clear");
  done_idle_a: assert property (done |=> state_r == uabd_pkg::UABD_IDLE)
    else $error("sequence did not stop at the fifth edge");
  tick_gate_a: assert property (state_r != uabd_pkg::UABD_COUNT |=> !tif.tick)
    else $error("counter clock ran outside counting");
  tx_lock_a: assert property (auto_rate_enable |=> tx_lockout)
    else $error("transmitter not locked out");
  idle_release_a: assert property (state_r == uabd_pkg::UABD_IDLE |=> !rx_hold_idle)
    else $error("receiver held idle with no sequence");
  flag_clear_a: assert property (reg_rd && reg_addr == uabd_pkg::ADDR_RX_BUF && !done |=> !receive_flag_r)
    else $error("receive flag not cleared by buffer read");
  ovf_write_a: assert property (reg_wr && reg_addr == uabd_pkg::ADDR_CTRL && !ovf_evt |=>
                                ctrl_r[uabd_pkg::CTRL_OVF_BIT] == $past(reg_wdata[uabd_pkg::CTRL_OVF_BIT]))
    else $error("overflow bit not written");
  div_write_a: assert property (reg_wr && reg_addr == uabd_pkg::ADDR_DIV_HIGH
                                && state_r == uabd_pkg::UABD_WAIT_START |=> div_r[15:8] == $past(reg_wdata))
    else $error("divisor preload lost");
  irq_quiet_a: assert property (!(|(irq_stat_nxt & irq_mask_r)) |=> !irq)
    else $error("interrupt raised with nothing pending");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  status_read_a: assert property (reg_rd && reg_addr == uabd_pkg::ADDR_IRQ_STATUS |=>
                                  reg_rdata == {6'h0, $past(irq_stat_r)})
    else $error("interrupt status read wrong");

  done_c: cover property (done);
  ovf_c: cover property (ovf_evt);
  wake_c: cover property (state_r == uabd_pkg::UABD_WAIT_BREAK && rise ##1 state_r == uabd_pkg::UABD_WAIT_START);
  tx_block_c: cover property (auto_rate_enable && reg_wr && reg_addr == uabd_pkg::ADDR_TX_BUF);
endmodule

// ===== verification/uabd_remote_tx.sv
// ==========================================================
// far-end transmitter: paces the line from the bench clock
module uabd_remote_tx (
  input wire logic clk_sys, // pacing clock
  output logic line // serial line, idles high
);
  timeunit 1ns;
  timeprecision 1ps;

  initial line = 1'b1;

  // each level lasts exactly the given number of clocks
  task automatic hold(input logic v, input int unsigned clocks);
    @(posedge clk_sys);
    line <= v;
    repeat (clocks - 1) @(posedge clk_sys);
  endtask

  // one start bit, eight data bits lsb first, one stop bit
  task automatic send_frame(input int unsigned bitclk, input logic [7:0] data);
    hold(1'b0, bitclk);
    for (int i = 0; i < 8; i++) hold(data[i], bitclk);
    hold(1'b1, bitclk);
  endtask

  // long low, then one idle bit before the next byte
  task automatic send_break(input int unsigned bitclk);
    hold(1'b0, 13 * bitclk);
    hold(1'b1, bitclk);
  endtask
endmodule

// ===== verification/uart_auto_baud_detect_bench.sv
module uart_auto_baud_detect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] lo; logic [7:0] hi;} uabd_note_s;
  logic clk_sys, reset, reg_wr, reg_rd, serial_input_pin, irq, rate_tick, tx_lockout, tx_load, rx_hold_idle;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_data, e;
  uabd_note_s exp_q[$];
  uabd_note_s note;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int n_load = 0;
  logic rd_seen = 1'b0;

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  uabd_top dut_u (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .serial_input_pin(serial_input_pin), .irq(irq), .rate_tick(rate_tick),
    .tx_lockout(tx_lockout), .tx_load(tx_load), .tx_data(tx_data), .rx_hold_idle(rx_hold_idle));
  uabd_remote_tx rtx_u (.clk_sys(clk_sys), .line(serial_input_pin));

  // ==========================================================
  // checking and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen) begin
      note = exp_q.pop_front();
      if (note.lo == note.hi) check({8'h00, reg_rdata}, {8'h00, note.lo});
      else check({15'h0, reg_rdata >= note.lo && reg_rdata <= note.hi}, 16'h1);
    end
    rd_seen <= reg_rd;
    if (tx_load === 1'b1) n_load <= n_load + 1;
    cycles++;
    if (cycles == 90000) begin
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
    end
  end

  // ==========================================================
  // register bus
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
    uabd_note_s n;
    n.lo = lo;
    n.hi = hi;
    exp_q.push_back(n);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  function automatic int unsigned base_of(input logic [1:0] sel);
    case (sel)
      2'b00: return uabd_pkg::PRESC_DIV_00;
      2'b01: return uabd_pkg::PRESC_DIV_01;
      2'b10: return uabd_pkg::PRESC_DIV_10;
      default: return uabd_pkg::PRESC_DIV_11;
    endcase
  endfunction

  function automatic int unsigned q_of(input logic [1:0] sel);
    case (sel)
      2'b00: return uabd_pkg::GEN_Q_NARROW_LS;
      2'b11: return uabd_pkg::GEN_Q_WIDE_HS;
      default: return uabd_pkg::GEN_Q_MID;
    endcase
  endfunction

  // ==========================================================
  // one measurement; sel is {wide, high speed}
  task automatic measure(input logic [1:0] sel, input logic wake);
    int unsigned n;
    int loads;
    logic [7:0] ctrl;
    n = 5 + $urandom % 3;
    ctrl = {3'b000, sel[0], sel[1], 1'b1, wake, 1'b1};
    wr(uabd_pkg::ADDR_DIV_LOW, 8'h5a);
    wr(uabd_pkg::ADDR_CTRL, ctrl);
    repeat (3) @(posedge clk_sys);
    rd(uabd_pkg::ADDR_DIV_LOW, 8'h00, 8'h00);
    check({15'h0, tx_lockout}, 16'h1);
    check({15'h0, rx_hold_idle}, 16'h1);
    loads = n_load;
    wr(uabd_pkg::ADDR_TX_BUF, 8'h3c);
    if (wake) rtx_u.send_break(base_of(sel) * n);
    rtx_u.send_frame(base_of(sel) * n, 8'h55);
    check(16'(n_load), 16'(loads));
    repeat (8) @(posedge clk_sys);
    check({15'h0, rx_hold_idle}, 16'h0);
    check({15'h0, tx_lockout}, 16'h0);
    check({15'h0, irq}, 16'h0);
    rd(uabd_pkg::ADDR_CTRL, ctrl & 8'hfc, ctrl & 8'hfc);
    // counter ticks every eighth prescaled clock: n over the eight bit times measured, phase gives one either way
    rd(uabd_pkg::ADDR_DIV_LOW, 8'(n - 1), 8'(n + 1));
    rd(uabd_pkg::ADDR_DIV_HIGH, 8'h00, 8'h00);
    rd(uabd_pkg::ADDR_STATUS, 8'h01, 8'h01);
    wr(uabd_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (2) @(posedge clk_sys);
    check({15'h0, irq}, 16'h1);
    rd(uabd_pkg::ADDR_IRQ_STATUS, 8'h01, 8'h01);
    repeat (3) @(posedge clk_sys);
    check({15'h0, irq}, 16'h0);
    wr(uabd_pkg::ADDR_IRQ_MASK, 8'h00);
    rd(uabd_pkg::ADDR_RX_BUF, 8'h00, 8'h00);
    rd(uabd_pkg::ADDR_STATUS, 8'h00, 8'h00);
    wr(uabd_pkg::ADDR_TX_BUF, 8'ha5);
    repeat (2) @(posedge clk_sys);
    check(16'(n_load), 16'(loads + 1));
    check({8'h00, tx_data}, 16'h00a5);
    $display("test measure sel %b wake %b done", sel, wake);
  endtask

  // preload the counter while waiting for the start bit, so the first tick rolls it over
  task automatic overflow_run();
    int unsigned n;
    n = 5 + $urandom % 3;
    wr(uabd_pkg::ADDR_CTRL, 8'h1d);
    repeat (3) @(posedge clk_sys);
    wr(uabd_pkg::ADDR_DIV_LOW, 8'hff);
    wr(uabd_pkg::ADDR_DIV_HIGH, 8'hff);
    rtx_u.send_frame(base_of(2'b11) * n, 8'h55);
    repeat (8) @(posedge clk_sys);
    rd(uabd_pkg::ADDR_CTRL, 8'h9c, 8'h9c);
    // first tick wraps to zero, the rest count on: n - 2 give or take one
    rd(uabd_pkg::ADDR_DIV_LOW, 8'(n - 3), 8'(n - 1));
    rd(uabd_pkg::ADDR_DIV_HIGH, 8'h00, 8'h00);
    rd(uabd_pkg::ADDR_IRQ_STATUS, 8'h03, 8'h03);
    rd(uabd_pkg::ADDR_RX_BUF, 8'h00, 8'h00);
    wr(uabd_pkg::ADDR_CTRL, 8'h04);
    rd(uabd_pkg::ADDR_CTRL, 8'h04, 8'h04);
    $display("test overflow done");
  endtask

  task automatic next_tick(output int t);
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (rate_tick !== 1'b1 && t < 4000);
  endtask

  // first period after a change may still run on old settings
  task automatic rate_gen(input logic [1:0] sel);
    logic [7:0] n;
    int t;
    n = 8'(2 + $urandom % 6);
    wr(uabd_pkg::ADDR_DIV_LOW, n);
    wr(uabd_pkg::ADDR_DIV_HIGH, 8'h00);
    wr(uabd_pkg::ADDR_CTRL, {3'b000, sel[0], sel[1], 3'b100});
    next_tick(t);
    next_tick(t);
    next_tick(t);
    check(16'(t), 16'(q_of(sel) * (n + 1)));
    $display("test rate sel %b done", sel);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    void'($urandom(32'h44985a4b));
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      e = (a == 0) ? uabd_pkg::CTRL_RESET : 8'h00;
      rd(3'(a), e, e);
    end
    $display("test reset values done");
    wr(uabd_pkg::ADDR_DIV_LOW, 8'h5a);
    wr(uabd_pkg::ADDR_CTRL, 8'h01);
    repeat (4) @(posedge clk_sys);
    check({15'h0, rx_hold_idle}, 16'h0);
    rd(uabd_pkg::ADDR_DIV_LOW, 8'h5a, 8'h5a);
    wr(uabd_pkg::ADDR_CTRL, 8'h84);
    rd(uabd_pkg::ADDR_CTRL, 8'h84, 8'h84);
    wr(uabd_pkg::ADDR_CTRL, 8'h04);
    rd(uabd_pkg::ADDR_CTRL, 8'h04, 8'h04);
    $display("test gating and overflow bit done");
    for (int i = 0; i < 5; i++) measure((i == 4) ? 2'b11 : 2'(i), i == 4);
    overflow_run();
    for (int i = 0; i < 4; i++) rate_gen(2'(i));
    repeat (4) @(posedge clk_sys);
    check(16'(exp_q.size()), 16'h0);
    tally_and_finish();
  end
endmodule
